/* File: core/dpram_pkg.sv */
// Shared types and constants for the synchronous dual-port RAM
package dpram_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int ADDR_MAX_W = 15;    // Full address width of a port
  localparam int DATA_W     = 16;    // Word width
  localparam int BYTE_W     = 8;     // Width of one byte lane
  localparam int BYTE_CNT   = 2;     // Byte lanes per word
  localparam int PORT_CNT   = 2;     // Independent access ports

  // ---------------------------------------------------------------
  // Encodings and reset values
  // ---------------------------------------------------------------
  localparam logic                  RW_READ       = 1'b1;
  localparam logic                  MODE_PIPE     = 1'b1;
  localparam logic [ADDR_MAX_W-1:0] ADDR_ZERO     = 15'h0000;
  localparam logic [ADDR_MAX_W-1:0] ADDR_STEP     = 15'h0001;
  localparam logic [DATA_W-1:0]     DATA_RST      = 16'h0000;
  localparam logic [BYTE_CNT-1:0]   DRIVE_NONE    = 2'h0;

  // ---------------------------------------------------------------
  // Port carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic                  chipSelectLowActive;
    logic                  chipSelectHighActive;
    logic                  upperByteSelectN;
    logic                  lowerByteSelectN;
    logic                  readWriteN;        // 1 read, 0 write
    logic                  outputEnableN;     // Asynchronous
    logic                  addressLoadStrobeN;
    logic                  countAdvanceN;
    logic                  countClearN;
    logic                  outputStageSelect; // 1 pipelined
    logic [ADDR_MAX_W-1:0] addr;
    logic [DATA_W-1:0]     wrData;
  } portIn_t;

  typedef struct packed {
    logic [DATA_W-1:0]   rdData;
    logic [BYTE_CNT-1:0] dataOe;   // Per byte, high while driving
    logic                standby;
  } portOut_t;

  typedef struct packed {
    logic [ADDR_MAX_W-1:0] addr;      // Internal address register
    logic [DATA_W-1:0]     rdFlow;    // First read stage
    logic [BYTE_CNT-1:0]   drvFlow;   // Byte drive for first stage
    logic [DATA_W-1:0]     outData;
    logic [BYTE_CNT-1:0]   outDrive;
    logic                  standby;
  } portState_t;

  typedef struct packed {
    portState_t [PORT_CNT-1:0] ports;
  } state_t;

endpackage : dpram_pkg

/* File: core/sync_dual_port_ram.sv */
// Synchronous true dual-port RAM with per-port address counters
`timescale 1ns/1ns
`default_nettype none

module sync_dual_port_ram #(
  parameter int DEPTH_W = 15  // 14 for the half-depth variant
) (
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire dpram_pkg::portIn_t portIn  [dpram_pkg::PORT_CNT],
  output var  dpram_pkg::portOut_t portOut [dpram_pkg::PORT_CNT]
);
  import dpram_pkg::*;

  // ---------------------------------------------------------------
  // Storage and working signals
  // ---------------------------------------------------------------
  localparam int DEPTH = 1 << DEPTH_W;
  localparam logic [ADDR_MAX_W-1:0] ADDR_MASK =
    ADDR_MAX_W'((1 << DEPTH_W) - 1);

  // Unused top address bit on the small variant is masked off
  logic [DATA_W-1:0]     mem [DEPTH];

  state_t                st_reg;
  state_t                st_next;
  logic [ADDR_MAX_W-1:0] usedAddr [PORT_CNT];
  logic                  selected [PORT_CNT];
  logic [BYTE_CNT-1:0]   byteOn   [PORT_CNT];
  logic [BYTE_CNT-1:0]   wrEn     [PORT_CNT];
  logic [DATA_W-1:0]     rdWord   [PORT_CNT];

  // ---------------------------------------------------------------
  // Address counter
  // ---------------------------------------------------------------
  // Clear beats load, load beats advance, otherwise hold
  function automatic logic [ADDR_MAX_W-1:0] nextAddr(
    input portIn_t               pin,
    input logic [ADDR_MAX_W-1:0] prev
  );
    logic [ADDR_MAX_W-1:0] a;
    a = prev;
    if (!pin.countClearN) begin
      a = ADDR_ZERO;
    end else if (!pin.addressLoadStrobeN) begin
      a = pin.addr;
    end else if (!pin.countAdvanceN) begin
      a = prev + ADDR_STEP;
    end
    return a & ADDR_MASK;
  endfunction : nextAddr

  // ---------------------------------------------------------------
  // Next-state logic for both ports
  // ---------------------------------------------------------------
  // Each port works only from its own inputs; the counter steps
  // whatever the selects say, since it lives ahead of the array.
  always_comb begin
    st_next = st_reg;
    for (int p = 0; p < PORT_CNT; p++) begin
      usedAddr[p] = nextAddr(portIn[p], st_reg.ports[p].addr);
      selected[p] = !portIn[p].chipSelectLowActive &&
                    portIn[p].chipSelectHighActive;
      byteOn[p]   = {!portIn[p].upperByteSelectN,
                     !portIn[p].lowerByteSelectN};
      wrEn[p]     = (selected[p] &&
                     portIn[p].readWriteN != RW_READ) ?
                    byteOn[p] : DRIVE_NONE;
      rdWord[p]   = mem[usedAddr[p][DEPTH_W-1:0]];
      st_next.ports[p].addr    = usedAddr[p];
      st_next.ports[p].standby = !selected[p];
      // First stage: word and byte drive for this edge's access
      if (selected[p] && portIn[p].readWriteN == RW_READ) begin
        st_next.ports[p].rdFlow  = rdWord[p];
        st_next.ports[p].drvFlow = byteOn[p];
      end else begin
        st_next.ports[p].drvFlow = DRIVE_NONE;
      end
      // Pipelined mode takes the first stage one edge later
      if (portIn[p].outputStageSelect == MODE_PIPE) begin
        st_next.ports[p].outData  = st_reg.ports[p].rdFlow;
        st_next.ports[p].outDrive = st_reg.ports[p].drvFlow;
      end else begin
        st_next.ports[p].outData  = st_next.ports[p].rdFlow;
        st_next.ports[p].outDrive = st_next.ports[p].drvFlow;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int p = 0; p < PORT_CNT; p++) begin
        st_reg.ports[p].addr     <= ADDR_ZERO;
        st_reg.ports[p].rdFlow   <= DATA_RST;
        st_reg.ports[p].drvFlow  <= DRIVE_NONE;
        st_reg.ports[p].outData  <= DATA_RST;
        st_reg.ports[p].outDrive <= DRIVE_NONE;
        st_reg.ports[p].standby  <= 1'b1;
      end
    end else begin
      st_reg <= st_next;
    end
  end

  // ---------------------------------------------------------------
  // Array write
  // ---------------------------------------------------------------
  // One edge finishes a write; the array has no reset. When both
  // ports write the same byte at once the higher port wins.
  always_ff @(posedge clk) begin
    for (int p = 0; p < PORT_CNT; p++) begin
      for (int b = 0; b < BYTE_CNT; b++) begin
        if (wrEn[p][b]) begin
          mem[usedAddr[p][DEPTH_W-1:0]][b*BYTE_W +: BYTE_W] <=
            portIn[p].wrData[b*BYTE_W +: BYTE_W];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // Port outputs
  // ---------------------------------------------------------------
  // Output enable is the one unclocked path, so the pad enable is
  // gated by it directly rather than waiting for an edge.
  always_comb begin
    for (int p = 0; p < PORT_CNT; p++) begin
      portOut[p].rdData  = st_reg.ports[p].outData;
      portOut[p].standby = st_reg.ports[p].standby;
      portOut[p].dataOe  = portIn[p].outputEnableN ?
                           DRIVE_NONE :
                           st_reg.ports[p].outDrive;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  for (genvar g = 0; g < PORT_CNT; g++) begin : g_chk
    localparam int O = PORT_CNT - 1 - g;

    sequence s_write(int unused);
      selected[g] && !portIn[g].readWriteN &&
      byteOn[g] == 2'h3 && portIn[g].countClearN &&
      !portIn[g].addressLoadStrobeN && wrEn[O] == DRIVE_NONE;
    endsequence

    sequence s_readSame(int unused);
      selected[g] && portIn[g].readWriteN &&
      byteOn[g] == 2'h3 &&
      portIn[g].outputStageSelect != MODE_PIPE &&
      usedAddr[g] == $past(usedAddr[g]) && wrEn[O] == DRIVE_NONE;
    endsequence

    property p_clearZero;
      !portIn[g].countClearN |=> st_reg.ports[g].addr == ADDR_ZERO;
    endproperty
    a_clearZero: assert property (p_clearZero)
      else $error("counter clear did not give address zero");

    property p_loadAddr;
      portIn[g].countClearN && !portIn[g].addressLoadStrobeN |=>
        st_reg.ports[g].addr == ($past(portIn[g].addr) & ADDR_MASK);
    endproperty
    a_loadAddr: assert property (p_loadAddr)
      else $error("load strobe did not load external address");

    property p_advance;
      portIn[g].countClearN && portIn[g].addressLoadStrobeN &&
      !portIn[g].countAdvanceN |=>
        st_reg.ports[g].addr ==
        (($past(st_reg.ports[g].addr) + ADDR_STEP) & ADDR_MASK);
    endproperty
    a_advance: assert property (p_advance)
      else $error("count advance did not step the address");

    property p_holdAddr;
      portIn[g].countClearN && portIn[g].addressLoadStrobeN &&
      portIn[g].countAdvanceN |=> $stable(st_reg.ports[g].addr);
    endproperty
    a_holdAddr: assert property (p_holdAddr)
      else $error("idle counter changed the address");

    property p_flowDeselect;
      !selected[g] && portIn[g].outputStageSelect != MODE_PIPE |=>
        st_reg.ports[g].outDrive == DRIVE_NONE &&
        st_reg.ports[g].standby;
    endproperty
    a_flowDeselect: assert property (p_flowDeselect)
      else $error("flow-through deselect not seen next cycle");

    property p_pipeDeselect;
      !selected[g] && portIn[g].outputStageSelect == MODE_PIPE
      ##1 portIn[g].outputStageSelect == MODE_PIPE |=>
        st_reg.ports[g].outDrive == DRIVE_NONE;
    endproperty
    a_pipeDeselect: assert property (p_pipeDeselect)
      else $error("pipelined deselect not seen two cycles on");

    property p_oeFloat;
      portIn[g].outputEnableN |-> portOut[g].dataOe == DRIVE_NONE;
    endproperty
    a_oeFloat: assert property (p_oeFloat)
      else $error("data driven while output enable high");

    property p_byteMask;
      selected[g] && portIn[g].readWriteN &&
      portIn[g].upperByteSelectN &&
      portIn[g].outputStageSelect != MODE_PIPE |=>
        !st_reg.ports[g].outDrive[1];
    endproperty
    a_byteMask: assert property (p_byteMask)
      else $error("upper byte driven with its select high");

    property p_pipeLate;
      portIn[g].outputStageSelect == MODE_PIPE && selected[g] &&
      portIn[g].readWriteN ##1
      portIn[g].outputStageSelect == MODE_PIPE |=>
        st_reg.ports[g].outData == $past(rdWord[g], 2);
    endproperty
    a_pipeLate: assert property (p_pipeLate)
      else $error("pipelined data not two edges after access");

    property p_writeRead;
      s_write(0) ##1 s_readSame(0) |=>
        st_reg.ports[g].outData == $past(portIn[g].wrData, 2);
    endproperty
    a_writeRead: assert property (p_writeRead)
      else $error("read after write returned stale data");

    // ---------------------------------------------------------------
    // Byte lanes of a write, seen by a read of the same word
    // ---------------------------------------------------------------
    // The array read is combinational, so the word at the next edge
    // already shows what this edge wrote. The other port must stay
    // quiet on the write edge, or its bytes could hide a lost write.
    sequence s_quietWrite(laneOn);
      selected[g] && !portIn[g].readWriteN &&
      wrEn[O] == DRIVE_NONE && laneOn;
    endsequence

    // Next edge uses the same word, whatever the counter controls said
    sequence s_sameWord;
      usedAddr[g] == $past(usedAddr[g]);
    endsequence

    property p_upperLands;
      s_quietWrite(!portIn[g].upperByteSelectN) ##1 s_sameWord |->
        rdWord[g][DATA_W-1:BYTE_W] ==
        $past(portIn[g].wrData[DATA_W-1:BYTE_W]);
    endproperty
    a_upperLands: assert property (p_upperLands)
      else $error("selected upper byte was not written");

    property p_lowerLands;
      s_quietWrite(!portIn[g].lowerByteSelectN) ##1 s_sameWord |->
        rdWord[g][BYTE_W-1:0] ==
        $past(portIn[g].wrData[BYTE_W-1:0]);
    endproperty
    a_lowerLands: assert property (p_lowerLands)
      else $error("selected lower byte was not written");

    property p_upperKept;
      s_quietWrite(portIn[g].upperByteSelectN) ##1 s_sameWord |->
        rdWord[g][DATA_W-1:BYTE_W] ==
        $past(rdWord[g][DATA_W-1:BYTE_W]);
    endproperty
    a_upperKept: assert property (p_upperKept)
      else $error("masked upper byte was overwritten");

    property p_lowerKept;
      s_quietWrite(portIn[g].lowerByteSelectN) ##1 s_sameWord |->
        rdWord[g][BYTE_W-1:0] == $past(rdWord[g][BYTE_W-1:0]);
    endproperty
    a_lowerKept: assert property (p_lowerKept)
      else $error("masked lower byte was overwritten");

    // ---------------------------------------------------------------
    // Output path
    // ---------------------------------------------------------------
    // Flow-through shows the word and its lanes one edge after the
    // access; the pipe adds one more edge, checked above.
    property p_flowRead;
      selected[g] && portIn[g].readWriteN &&
      portIn[g].outputStageSelect != MODE_PIPE |=>
        st_reg.ports[g].outData == $past(rdWord[g]) &&
        st_reg.ports[g].outDrive == $past(byteOn[g]);
    endproperty
    a_flowRead: assert property (p_flowRead)
      else $error("flow-through read not shown next cycle");

    property p_pipeLower;
      portIn[g].outputStageSelect == MODE_PIPE && selected[g] &&
      portIn[g].readWriteN && portIn[g].lowerByteSelectN
      ##1 portIn[g].outputStageSelect == MODE_PIPE |=>
        !st_reg.ports[g].outDrive[0];
    endproperty
    a_pipeLower: assert property (p_pipeLower)
      else $error("pipelined lower byte driven with select high");

    // Standby is a power flag, so it must drop on a selected edge
    property p_standbyOff;
      selected[g] |=> !st_reg.ports[g].standby;
    endproperty
    a_standbyOff: assert property (p_standbyOff)
      else $error("selected port still shows standby");

    property p_oeFollows;
      !portIn[g].outputEnableN |->
        portOut[g].dataOe == st_reg.ports[g].outDrive;
    endproperty
    a_oeFollows: assert property (p_oeFollows)
      else $error("output enable low but lanes not driven");
  end

endmodule : sync_dual_port_ram

`default_nettype wire

/* File: tb/host_model.sv */
// Host bus master model that sits on the far side of one RAM port
`timescale 1ns/1ns
`default_nettype none

module host_model #(
  parameter logic MODE = 1'b0  // Output stage chosen once per port
) (
  input  wire logic                clk,
  input  wire dpram_pkg::portIn_t  cmd,
  input  wire dpram_pkg::portOut_t resp,
  output var  dpram_pkg::portIn_t  drive,
  output var  logic [15:0]         busLevel
);
  import dpram_pkg::*;

  logic [DATA_W-1:0] lastLvl = DATA_RST;

  // ---------------------------------------------------------------
  // Requests and data lanes
  // ---------------------------------------------------------------
  // Caller moves cmd at falling clk and toggles output enable just after it; stage select is pinned
  always_comb begin
    drive = cmd;
    drive.outputStageSelect = MODE;
    // A released lane shows a changing pattern, never a held value
    for (int b = 0; b < BYTE_CNT; b++) begin
      busLevel[b*8 +: 8] = resp.dataOe[b] ? resp.rdData[b*8 +: 8]
                                          : ~lastLvl[b*8 +: 8];
    end
  end

  always @(posedge clk) lastLvl <= busLevel;
endmodule : host_model

`default_nettype wire

/* File: tb/test_sync_dual_port_ram.sv */
// Self-checking testbench for the dual-port RAM
`timescale 1ns/1ns
`default_nettype none

module test_sync_dual_port_ram;
  import dpram_pkg::*;

  typedef struct packed {
    logic [1:0]  mask;
    logic [15:0] wr;
    logic [15:0] exp;
  } row_t;

  localparam logic [2:0] LOAD = 3'b011;  // {load_n, advance_n, clear_n}
  localparam logic [2:0] ADV  = 3'b101;
  localparam logic [2:0] HOLD = 3'b111;

  logic        clk     = 1'b0;
  logic        sys_rst = 1'b1;
  portIn_t     cmd  [PORT_CNT];
  portIn_t     pin  [PORT_CNT];
  portOut_t    pout [PORT_CNT];
  logic [15:0] bus  [PORT_CNT];
  int          error_cnt  = 0;
  int          n_compared = 0;
  row_t rows [4] = '{'{2'b00, 16'h1111, 16'h1111},
                     '{2'b01, 16'h2222, 16'h22a5},
                     '{2'b10, 16'h3333, 16'ha533},
                     '{2'b11, 16'h4444, 16'ha5a5}};

  always #20 clk = ~clk;

  sync_dual_port_ram #(.DEPTH_W(6)) u_dut (
    .clk(clk), .sys_rst(sys_rst), .portIn(pin), .portOut(pout));
  host_model #(.MODE(1'b0)) u_host0 (
    .clk(clk), .cmd(cmd[0]), .resp(pout[0]), .drive(pin[0]),
    .busLevel(bus[0]));
  host_model #(.MODE(MODE_PIPE)) u_host1 (
    .clk(clk), .cmd(cmd[1]), .resp(pout[1]), .drive(pin[1]),
    .busLevel(bus[1]));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // One request, set at the falling edge so the rising edge takes it
  task automatic go(int p, logic sel, logic [1:0] m, logic rw,
                    logic [2:0] ctl, logic [14:0] a, logic [15:0] d);
    @(negedge clk);
    cmd[p] = {~sel, sel, m, rw, 1'b0, ctl, 1'b0, a, d};
  endtask : go

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  // ---------------------------------------------------------------
  // Sequence
  // ---------------------------------------------------------------
  // Both ports start deselected: the array holds no known word yet,
  // and port 1's pipe latency is then seen from idle
  initial begin
    cmd[0] = {1'b1, 1'b0, 2'b00, 1'b1, 1'b0, HOLD, 1'b0, 15'h0, 16'h0};
    cmd[1] = {1'b1, 1'b0, 2'b00, 1'b1, 1'b0, HOLD, 1'b0, 15'h0, 16'h0};
    repeat (8) @(posedge clk);
    check("rst standby", 16'(pout[0].standby), 16'h1);
    check("rst oe", 16'(pout[0].dataOe), 16'h0);
    check("rst data", pout[0].rdData, 16'h0);
    $display("reset test done");
    @(negedge clk);
    sys_rst = 1'b0;
    // Masked writes and reads, flow-through port
    foreach (rows[i]) begin
      go(0, 1, 2'b00, 1'b0, LOAD, 15'(i + 8), 16'ha5a5);
      go(0, 1, rows[i].mask, 1'b0, LOAD, 15'(i + 8), rows[i].wr);
      go(0, 1, 2'b00, RW_READ, LOAD, 15'(i + 8), 16'h0);
      go(0, 1, rows[i].mask, RW_READ, HOLD, 15'h0, 16'h0);
      check("row data", bus[0], rows[i].exp);
      go(0, 1, 2'b00, RW_READ, HOLD, 15'h0, 16'h0);
      check("row oe", 16'(pout[0].dataOe),
            16'(rows[i].mask ^ 2'b11));
      $display("row %0d done", i);
    end
    // Burst writes through the counter, wrapping past the top
    go(0, 1, 2'b00, 1'b0, LOAD, 15'd62, 16'hc03e);
    go(0, 1, 2'b00, 1'b0, ADV, 15'h0, 16'hc03f);
    go(0, 1, 2'b00, 1'b0, ADV, 15'h0, 16'hc000);
    go(0, 1, 2'b00, 1'b0, ADV, 15'h0, 16'hc001);
    go(0, 1, 2'b00, RW_READ, 3'b000, 15'd9, 16'h0);
    go(0, 0, 2'b00, RW_READ, ADV, 15'h0, 16'h0);
    check("clear", bus[0], 16'hc000);
    go(0, 1, 2'b00, RW_READ, HOLD, 15'd62, 16'h0);
    check("standby", 16'(pout[0].standby), 16'h1);
    check("desel oe", 16'(pout[0].dataOe), 16'h0);
    go(0, 0, 2'b00, RW_READ, LOAD, 15'd62, 16'h0);
    check("adv desel", bus[0], 16'hc001);
    go(0, 1, 2'b00, RW_READ, HOLD, 15'h0, 16'h0);
    go(0, 1, 2'b00, RW_READ, ADV, 15'h0, 16'h0);
    check("load desel", bus[0], 16'hc03e);
    go(0, 1, 2'b00, RW_READ, HOLD, 15'h0, 16'h0);
    check("advance", bus[0], 16'hc03f);
    #1 cmd[0].outputEnableN = 1'b1;
    #1 check("oe off", 16'(pout[0].dataOe), 16'h0);
    cmd[0].outputEnableN = 1'b0;
    #1 check("oe on", 16'(pout[0].dataOe), 16'h3);
    $display("counter test done");
    // Pipelined port reads words written by the other port
    go(1, 1, 2'b00, RW_READ, LOAD, 15'd62, 16'h0);
    go(1, 1, 2'b00, RW_READ, HOLD, 15'h0, 16'h0);
    check("pipe early", 16'(pout[1].dataOe), 16'h0);
    check("pipe active", 16'(pout[1].standby), 16'h0);
    go(1, 1, 2'b01, RW_READ, ADV, 15'h0, 16'h0);
    check("pipe data", bus[1], 16'hc03e);
    go(1, 0, 2'b00, RW_READ, HOLD, 15'h0, 16'h0);
    check("pipe hold", 16'(pout[1].dataOe), 16'h3);
    go(1, 0, 2'b00, RW_READ, HOLD, 15'h0, 16'h0);
    check("pipe byte", 16'(pout[1].dataOe), 16'h2);
    check("pipe upper", 16'(bus[1][15:8]), 16'hc0);
    check("pipe standby", 16'(pout[1].standby), 16'h1);
    go(1, 0, 2'b00, RW_READ, HOLD, 15'h0, 16'h0);
    check("pipe desel", 16'(pout[1].dataOe), 16'h0);
    $display("pipeline test done");
    wrap_up();
  end

  // Whole run is under 100 cycles; this span leaves ample margin
  initial begin
    #100000;
    error_cnt++;
    wrap_up();
  end
endmodule : test_sync_dual_port_ram

`default_nettype wire
